// ---- rtl/abe_core.sv ----
// Execute unit for arithmetic, logic, compare, skip and branch instructions.
// Assumes asynchronous program memory and I/O reads on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "abe_defs.svh"
module abe_core (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Program memory
	output logic [15:0] pm_addr_o,
	input wire logic [15:0] pm_data_i,
	// I/O space
	output logic [5:0] io_addr_o,
	output logic io_re_o,
	output logic io_we_o,
	output logic [7:0] io_wdata_o,
	input wire logic [7:0] io_rdata_i,
	// Flags kept by the rest of the core
	input wire logic irq_en_i,
	input wire logic t_flag_i,
	// Status flag register
	output var abe_pkg::abe_flags_t status_o
);
	logic rst_meta;
	logic rst_n;
	abe_pkg::abe_core_t s;
	abe_pkg::abe_core_t next_s;
	abe_pkg::abe_alu_kind_t alu_kind;
	abe_pkg::abe_alu_out_t alu_o;
	logic [7:0] alu_b;
	logic alu_cin;
	logic [7:0] qa;
	logic [7:0] qb;
	logic [7:0] opa;
	logic [7:0] opb;
	logic wr_en;
	logic [4:0] wr_addr;
	logic [7:0] wr_data;
	logic fetch;
	logic upd_ar;
	logic upd_lg;
	logic skip_take;
	logic two_word;
	logic br_take;
	logic is_word;
	logic is_pj;
	logic is_cmp;
	logic is_bitwr;
	logic io_ok;
	logic [7:0] io_mask;
	logic [15:0] wres;
	logic [15:0] br_target;
	logic [3:0] op;
	logic [3:0] rrf;

	// Operand addresses for a newly fetched word
	function automatic logic [9:0] read_addrs(input logic [15:0] w);
		logic [4:0] pr;
		pr = 5'(`ABE_WORD_BASE + {2'b00, w[7:6], 1'b0});
		case (w[15:12])
			`ABE_OP_RR0, `ABE_OP_RR1, `ABE_OP_RR2: read_addrs = {w[9:5], w[4:0]};
			`ABE_OP_SUB_IMM, `ABE_OP_SUBC_IMM, `ABE_OP_AND_IMM,
			`ABE_OP_OR_IMM, `ABE_OP_CMP_IMM: read_addrs = {1'b1, w[11:8], 5'h00};
			`ABE_OP_UNARY: begin
				if (w[11:10] == `ABE_UG_POINTER_JUMP) begin
					read_addrs = {`ABE_Z_LOW, `ABE_Z_HIGH};
				end else begin
					read_addrs = {w[4:0], 5'h00};
				end
			end
			`ABE_OP_ADD_IMM_WORD, `ABE_OP_SUB_IMM_WORD: read_addrs = {pr, 5'(pr + 5'h01)};
			default: read_addrs = 10'h000;
		endcase
	endfunction

	// Reset release
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	abe_regfile u_regs (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.ra_i(next_s.ra),
		.rb_i(next_s.rb),
		.qa_o(qa),
		.qb_o(qb),
		.we_i(wr_en),
		.wa_i(wr_addr),
		.wd_i(wr_data)
	);

	abe_alu u_alu (
		.a_i(opa),
		.b_i(alu_b),
		.cin_i(alu_cin),
		.kind_i(alu_kind),
		.out_o(alu_o)
	);

	// Operands, with the last write forwarded
	assign opa = (s.fwd_ok && s.fwd_a == s.ra) ? s.fwd_d : qa;
	assign opb = (s.fwd_ok && s.fwd_a == s.rb) ? s.fwd_d : qb;
	assign op = s.ir[15:12];
	assign rrf = {s.ir[13:12], s.ir[11:10]};
	assign two_word = (pm_data_i[15:12] == `ABE_OP_LONG);
	assign io_mask = 8'(8'h01 << s.ir[2:0]);
	assign br_target = 16'(s.pc + {{9{s.ir[6]}}, s.ir[6:0]});
	assign io_ok = (s.io_addr < `ABE_IO_BIT_LIMIT)
		&& s.io_addr != `ABE_RESERVED_IO_SLOT_0
		&& s.io_addr != `ABE_RESERVED_IO_SLOT_1
		&& s.io_addr != `ABE_RESERVED_IO_SLOT_2;

	always_comb begin
		next_s = s;
		next_s.fl.i = irq_en_i;
		next_s.fl.t = t_flag_i;
		next_s.io_we = 1'b0;
		next_s.io_re = 1'b0;
		alu_kind = abe_pkg::ALU_ADD;
		alu_b = opb;
		alu_cin = 1'b0;
		wr_en = 1'b0;
		wr_addr = s.ra;
		wr_data = alu_o.res;
		fetch = 1'b0;
		upd_ar = 1'b0;
		upd_lg = 1'b0;
		skip_take = 1'b0;
		br_take = 1'b0;
		is_word = 1'b0;
		is_pj = 1'b0;
		is_cmp = 1'b0;
		is_bitwr = 1'b0;
		wres = 16'h0000;
		case (s.st)
			abe_pkg::ST_EXEC: begin
				fetch = 1'b1;
				if (s.ir_ok) begin
					case (op)
						`ABE_OP_RR0, `ABE_OP_RR1, `ABE_OP_RR2: begin
							case (rrf)
								`ABE_RR_ADD, `ABE_RR_ADDC: begin
									alu_cin = rrf[0] & s.fl.c;
									upd_ar = 1'b1;
									wr_en = 1'b1;
								end
								`ABE_RR_SUB, `ABE_RR_SUBC: begin
									alu_kind = abe_pkg::ALU_SUB;
									alu_cin = rrf[0] & s.fl.c;
									upd_ar = 1'b1;
									wr_en = 1'b1;
								end
								`ABE_RR_AND, `ABE_RR_OR, `ABE_RR_XOR: begin
									alu_kind = (rrf == `ABE_RR_AND) ? abe_pkg::ALU_AND :
										(rrf == `ABE_RR_OR) ? abe_pkg::ALU_OR : abe_pkg::ALU_XOR;
									upd_lg = 1'b1;
									wr_en = 1'b1;
								end
								`ABE_RR_CMP, `ABE_RR_CMP_CARRY: begin
									alu_kind = abe_pkg::ALU_SUB;
									alu_cin = (rrf == `ABE_RR_CMP_CARRY) & s.fl.c;
									upd_ar = 1'b1;
									is_cmp = 1'b1;
								end
								`ABE_RR_CMP_SKIP_EQ: skip_take = (opa == opb);
								default: fetch = 1'b1;
							endcase
						end
						`ABE_OP_SUB_IMM, `ABE_OP_SUBC_IMM, `ABE_OP_CMP_IMM: begin
							alu_kind = abe_pkg::ALU_SUB;
							alu_b = s.ir[7:0];
							alu_cin = (op == `ABE_OP_SUBC_IMM) & s.fl.c;
							upd_ar = 1'b1;
							is_cmp = (op == `ABE_OP_CMP_IMM);
							wr_en = !is_cmp;
						end
						`ABE_OP_AND_IMM, `ABE_OP_OR_IMM: begin
							alu_kind = (op == `ABE_OP_AND_IMM) ? abe_pkg::ALU_AND : abe_pkg::ALU_OR;
							alu_b = s.ir[7:0];
							upd_lg = 1'b1;
							wr_en = 1'b1;
						end
						`ABE_OP_UNARY: begin
							case (s.ir[11:10])
								`ABE_UG_ONE_REG: begin
									case (s.ir[9:8])
										`ABE_UN_INC: alu_kind = abe_pkg::ALU_INC;
										`ABE_UN_DEC: alu_kind = abe_pkg::ALU_DEC;
										`ABE_UN_TEST: alu_kind = abe_pkg::ALU_AND;
										default: alu_kind = abe_pkg::ALU_AND;
									endcase
									// Clear is AND with zero, so a never-written register still ends at zero
									alu_b = (s.ir[9:8] == `ABE_UN_CLEAR) ? 8'h00 : opa;
									upd_lg = 1'b1;
									wr_en = (s.ir[9:8] != `ABE_UN_TEST);
								end
								`ABE_UG_SKIP_BIT_CLEAR: skip_take = !opa[s.ir[7:5]];
								`ABE_UG_SKIP_BIT_SET: skip_take = opa[s.ir[7:5]];
								default: begin
									is_pj = 1'b1;
									fetch = 1'b0;
									next_s.pc = {opb, opa};
									next_s.ir_ok = 1'b0;
									next_s.st = abe_pkg::ST_BUB;
								end
							endcase
						end
						`ABE_OP_ADD_IMM_WORD, `ABE_OP_SUB_IMM_WORD: begin
							is_word = 1'b1;
							fetch = 1'b0;
							wres = (op == `ABE_OP_ADD_IMM_WORD) ? 16'({opb, opa} + {10'h000, s.ir[5:0]})
								: 16'({opb, opa} - {10'h000, s.ir[5:0]});
							wr_en = 1'b1;
							wr_data = wres[7:0];
							next_s.whi = wres[15:8];
							next_s.ir_ok = 1'b0;
							next_s.st = abe_pkg::ST_WORD;
							next_s.fl.n = wres[15];
							next_s.fl.z = (wres == 16'h0000);
							if (op == `ABE_OP_ADD_IMM_WORD) begin
								next_s.fl.v = !opb[7] & wres[15];
								next_s.fl.c = !wres[15] & opb[7];
							end else begin
								next_s.fl.v = opb[7] & !wres[15];
								next_s.fl.c = wres[15] & !opb[7];
							end
							next_s.fl.s = wres[15] ^ next_s.fl.v;
						end
						`ABE_OP_IO_BIT: begin
							if (s.ir[11]) begin
								skip_take = (io_rdata_i[s.ir[2:0]] == s.ir[10]);
							end else begin
								is_bitwr = 1'b1;
								fetch = 1'b0;
								next_s.ir_ok = 1'b0;
								next_s.st = abe_pkg::ST_IOWR;
								next_s.io_we = io_ok;
								// Whole register rewritten; flags read as set get a one back
								next_s.io_wd = s.ir[10] ? (io_rdata_i | io_mask)
									: (io_rdata_i & ~io_mask);
							end
						end
						`ABE_OP_BRANCH_FLAG: begin
							// Sign slot decided on N xor V; carry, zero, N, V, H, T, I by their bits
							br_take = (s.ir[10:8] == `ABE_FLAG_SIGN)
								? ((s.fl.n ^ s.fl.v) == s.ir[11])
								: (s.fl[s.ir[10:8]] == s.ir[11]);
							if (br_take) begin
								fetch = 1'b0;
								next_s.pc = br_target;
								next_s.ir_ok = 1'b0;
								next_s.st = abe_pkg::ST_BUB;
							end
						end
						`ABE_OP_LONG: begin
							fetch = 1'b0;
							next_s.pc = 16'(s.pc + 16'h0001);
							next_s.ir_ok = 1'b0;
							next_s.st = abe_pkg::ST_BUB;
						end
						default: fetch = 1'b1;
					endcase
					if (skip_take) begin
						fetch = 1'b0;
						next_s.ir_ok = 1'b0;
						next_s.pc = 16'(s.pc + (two_word ? 16'h0002 : 16'h0001));
						next_s.st = two_word ? abe_pkg::ST_BUB2 : abe_pkg::ST_BUB;
					end
				end
			end
			abe_pkg::ST_WORD: begin
				wr_en = 1'b1;
				wr_addr = 5'(s.ra + 5'h01);
				wr_data = s.whi;
				fetch = 1'b1;
			end
			abe_pkg::ST_IOWR, abe_pkg::ST_BUB: fetch = 1'b1;
			abe_pkg::ST_BUB2: next_s.st = abe_pkg::ST_BUB;
			default: next_s.st = abe_pkg::ST_EXEC;
		endcase
		if (upd_ar) begin
			next_s.fl.h = alu_o.h;
			next_s.fl.c = alu_o.c;
		end
		if (upd_ar || upd_lg) begin
			next_s.fl.v = alu_o.v;
			next_s.fl.n = alu_o.n;
			next_s.fl.z = alu_o.z;
			next_s.fl.s = alu_o.n ^ alu_o.v;
		end
		if (fetch) begin
			next_s.ir = pm_data_i;
			next_s.ir_ok = 1'b1;
			next_s.pc = 16'(s.pc + 16'h0001);
			next_s.st = abe_pkg::ST_EXEC;
			next_s.io_re = (pm_data_i[15:12] == `ABE_OP_IO_BIT);
			next_s.io_addr = pm_data_i[8:3];
			{next_s.ra, next_s.rb} = read_addrs(pm_data_i);
		end
		next_s.fwd_ok = wr_en;
		next_s.fwd_a = wr_addr;
		next_s.fwd_d = wr_data;
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= abe_pkg::ST_EXEC;
			s.pc <= `ABE_PC_RESET;
			s.fl <= `ABE_FLAGS_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign pm_addr_o = s.pc;
	assign io_addr_o = s.io_addr;
	assign io_re_o = s.io_re;
	assign io_we_o = s.io_we;
	assign io_wdata_o = s.io_wd;
	assign status_o = s.fl;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n);

	chk_io_limit: assert property (io_we_o |-> io_addr_o < `ABE_IO_BIT_LIMIT)
		else $error("bit write outside low I/O range");
	chk_rmw_whole: assert property (is_bitwr && io_ok |=> io_we_o
		&& ((io_wdata_o | $past(io_mask)) == ($past(io_rdata_i) | $past(io_mask))))
		else $error("bit write did not keep the other bits");
	chk_arith_one: assert property (upd_ar |=> s.st == abe_pkg::ST_EXEC && s.ir_ok)
		else $error("arithmetic op took more than one cycle");
	chk_word_two: assert property (is_word |=> s.st == abe_pkg::ST_WORD
		##1 (s.st == abe_pkg::ST_EXEC && s.ir_ok))
		else $error("word op not two cycles");
	chk_logic_flags: assert property (upd_lg |=>
		((status_o ^ $past(status_o)) & 8'h21) == 8'h00)
		else $error("logic op touched carry or half carry");
	chk_jump_z: assert property (is_pj |=> pm_addr_o == {$past(opb), $past(opa)}
		&& ((status_o ^ $past(status_o)) & 8'h3f) == 8'h00)
		else $error("pointer jump target or flags wrong");
	chk_cmp_nowrite: assert property (is_cmp |-> !wr_en)
		else $error("compare stored a result");
	chk_skip_one: assert property (skip_take && !two_word |=> s.st == abe_pkg::ST_BUB
		##1 (s.st == abe_pkg::ST_EXEC && s.ir_ok))
		else $error("one-word skip not two cycles");
	chk_skip_two: assert property (skip_take && two_word |=> s.st == abe_pkg::ST_BUB2
		##1 s.st == abe_pkg::ST_BUB ##1 s.st == abe_pkg::ST_EXEC)
		else $error("two-word skip not three cycles");
	chk_branch_taken: assert property (br_take |=> pm_addr_o == $past(br_target)
		##1 s.st == abe_pkg::ST_EXEC)
		else $error("taken branch target or timing wrong");
	chk_signed_sel: assert property (s.st == abe_pkg::ST_EXEC && s.ir_ok
		&& op == `ABE_OP_BRANCH_FLAG && s.ir[10:8] == `ABE_FLAG_SIGN
		|-> br_take == ((status_o.n ^ status_o.v) == s.ir[11]))
		else $error("signed branch not decided on N xor V");
endmodule // abe_core
`default_nettype wire

// ---- rtl/abe_defs.svh ----
// Opcode fields, register slots, flag positions and reset values of the
// execute block. Assumes inclusion by bare name from the rtl folder.
`ifndef ABE_DEFS_SVH
`define ABE_DEFS_SVH

// Major opcode, instruction bits 15:12
`define ABE_OP_RR0 4'h0
`define ABE_OP_RR1 4'h1
`define ABE_OP_RR2 4'h2
`define ABE_OP_SUB_IMM 4'h3
`define ABE_OP_SUBC_IMM 4'h4
`define ABE_OP_AND_IMM 4'h5
`define ABE_OP_OR_IMM 4'h6
`define ABE_OP_CMP_IMM 4'h7
`define ABE_OP_UNARY 4'h8
`define ABE_OP_ADD_IMM_WORD 4'h9
`define ABE_OP_SUB_IMM_WORD 4'ha
`define ABE_OP_IO_BIT 4'hb
`define ABE_OP_BRANCH_FLAG 4'hc
`define ABE_OP_LONG 4'hd

// Register-register function, bits 13:10
`define ABE_RR_ADD 4'h0
`define ABE_RR_ADDC 4'h1
`define ABE_RR_SUB 4'h2
`define ABE_RR_SUBC 4'h3
`define ABE_RR_AND 4'h4
`define ABE_RR_OR 4'h5
`define ABE_RR_XOR 4'h6
`define ABE_RR_CMP 4'h7
`define ABE_RR_CMP_CARRY 4'h8
`define ABE_RR_CMP_SKIP_EQ 4'h9

// Unary group, bits 11:10 then 9:8
`define ABE_UG_ONE_REG 2'h0
`define ABE_UG_SKIP_BIT_CLEAR 2'h1
`define ABE_UG_SKIP_BIT_SET 2'h2
`define ABE_UG_POINTER_JUMP 2'h3
`define ABE_UN_INC 2'h0
`define ABE_UN_DEC 2'h1
`define ABE_UN_TEST 2'h2
`define ABE_UN_CLEAR 2'h3

// I/O bit group, bits 11:10
`define ABE_IOB_CLEAR 2'h0
`define ABE_IOB_SET 2'h1
`define ABE_IOB_SKIP_CLEAR 2'h2
`define ABE_IOB_SKIP_SET 2'h3

// I/O space
`define ABE_IO_BIT_LIMIT 6'h20
`define ABE_RESERVED_IO_SLOT_0 6'h00
`define ABE_RESERVED_IO_SLOT_1 6'h01
`define ABE_RESERVED_IO_SLOT_2 6'h02

// Flag positions in the status flag register
`define ABE_FLAG_SIGN 3'h4

// Register numbers
`define ABE_Z_LOW 5'h1e
`define ABE_Z_HIGH 5'h1f
`define ABE_WORD_BASE 5'h18

// Reset values
`define ABE_PC_RESET 16'h0000
`define ABE_FLAGS_RESET 8'h00

`endif

// ---- rtl/abe_pkg.sv ----
// Types shared by the execute block.
// Assumes abe_defs.svh for all numeric constants.
package abe_pkg;

	typedef struct packed {
		logic i;
		logic t;
		logic h;
		logic s;
		logic v;
		logic n;
		logic z;
		logic c;
	} abe_flags_t;

	typedef enum logic [2:0] {
		ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_INC, ALU_DEC
	} abe_alu_kind_t;

	typedef struct packed {
		logic [7:0] res;
		logic h;
		logic v;
		logic n;
		logic z;
		logic c;
	} abe_alu_out_t;

	typedef enum logic [4:0] {
		ST_EXEC = 5'h01,
		ST_WORD = 5'h02,
		ST_IOWR = 5'h04,
		ST_BUB = 5'h08,
		ST_BUB2 = 5'h10
	} abe_state_t;

	typedef struct packed {
		abe_state_t st;
		logic [15:0] pc;
		logic [15:0] ir;
		logic ir_ok;
		logic [4:0] ra;
		logic [4:0] rb;
		abe_flags_t fl;
		logic [7:0] whi;
		logic fwd_ok;
		logic [4:0] fwd_a;
		logic [7:0] fwd_d;
		logic [5:0] io_addr;
		logic [7:0] io_wd;
		logic io_we;
		logic io_re;
	} abe_core_t;

endpackage

// ---- rtl/abe_alu.sv ----
// Eight-bit arithmetic and logic unit with flag outputs.
// Assumes operands and carry come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module abe_alu (
	// Operands
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic cin_i,
	input wire abe_pkg::abe_alu_kind_t kind_i,
	// Result
	output var abe_pkg::abe_alu_out_t out_o
);
	logic [8:0] sum;
	logic [7:0] r;

	always_comb begin
		case (kind_i)
			abe_pkg::ALU_ADD: sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
			abe_pkg::ALU_SUB: sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
			abe_pkg::ALU_AND: sum = {1'b0, a_i & b_i};
			abe_pkg::ALU_OR: sum = {1'b0, a_i | b_i};
			abe_pkg::ALU_XOR: sum = {1'b0, a_i ^ b_i};
			abe_pkg::ALU_INC: sum = {1'b0, 8'(a_i + 8'h01)};
			abe_pkg::ALU_DEC: sum = {1'b0, 8'(a_i - 8'h01)};
			default: sum = 9'h000;
		endcase
		r = sum[7:0];
		out_o.res = r;
		out_o.n = r[7];
		out_o.z = (r == 8'h00);
		out_o.c = sum[8];
		out_o.h = 1'b0;
		out_o.v = 1'b0;
		case (kind_i)
			abe_pkg::ALU_ADD: begin
				out_o.h = (a_i[3] & b_i[3]) | (b_i[3] & ~r[3]) | (~r[3] & a_i[3]);
				out_o.v = (a_i[7] & b_i[7] & ~r[7]) | (~a_i[7] & ~b_i[7] & r[7]);
			end
			abe_pkg::ALU_SUB: begin
				out_o.h = (~a_i[3] & b_i[3]) | (b_i[3] & r[3]) | (r[3] & ~a_i[3]);
				out_o.v = (a_i[7] & ~b_i[7] & ~r[7]) | (~a_i[7] & b_i[7] & r[7]);
			end
			abe_pkg::ALU_INC: out_o.v = (r == 8'h80);
			abe_pkg::ALU_DEC: out_o.v = (r == 8'h7f);
			default: out_o.v = 1'b0;
		endcase
	end
endmodule // abe_alu
`default_nettype wire

// ---- rtl/abe_regfile.sv ----
// Thirty-two working registers, two registered read ports, one write port.
// Assumes the caller forwards a write made at the same edge as a read.
`timescale 1ns/1ns
`default_nettype none
module abe_regfile (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Read ports
	input wire logic [4:0] ra_i,
	input wire logic [4:0] rb_i,
	output logic [7:0] qa_o,
	output logic [7:0] qb_o,
	// Write port
	input wire logic we_i,
	input wire logic [4:0] wa_i,
	input wire logic [7:0] wd_i
);
	logic [7:0] mem [0:31];

	always_ff @(posedge clock_i) begin
		if (we_i) begin
			mem[wa_i] <= wd_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			qa_o <= 8'h00;
			qb_o <= 8'h00;
		end else begin
			qa_o <= mem[ra_i];
			qb_o <= mem[rb_i];
		end
	end
endmodule // abe_regfile
`default_nettype wire

// ---- verification/abe_far_side.sv ----
// Far-side model: program memory and the I/O register space.
// Assumes the bench preloads both arrays while the core is held in reset.
`timescale 1ns/1ns
`default_nettype none
module abe_far_side (
	// Clock
	input wire logic clock_i,
	// Program memory
	input wire logic [15:0] pm_addr_i,
	output logic [15:0] pm_data_o,
	// I/O space
	input wire logic [5:0] io_addr_i,
	input wire logic io_re_i,
	input wire logic io_we_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o
);
	// Bits 7:6 of every register are write-one-to-clear flags
	localparam logic [7:0] W1C = 8'hc0;
	logic [15:0] rom [256];
	logic [7:0] io [64];
	logic [7:0] last = 8'h5a;

	assign pm_data_o = rom[pm_addr_i[7:0]];
	// Stale read data is inverted outside a read
	assign io_rdata_o = io_re_i ? io[io_addr_i] : ~last;

	always @(posedge clock_i) begin
		if (io_re_i)
			last <= io[io_addr_i];
		if (io_we_i)
			io[io_addr_i] <= (io[io_addr_i] & ~io_wdata_i & W1C) | (io_wdata_i & ~W1C);
	end
endmodule // abe_far_side
`default_nettype wire

// ---- verification/alu_branch_execute_tb_top.sv ----
// Bench: random programs run on the execute block, writes scored.
// Assumes abe_pkg is compiled and the far-side model answers at once.
`timescale 1ns/1ns
`default_nettype none
module alu_branch_execute_tb_top;
	typedef struct packed {
		logic [5:0] a;
		logic [7:0] d;
		logic [7:0] f;
		logic [7:0] dt;
	} abe_note_t;
	logic clock_i, nrst_i, io_re_o, io_we_o, irq_en_i, t_flag_i;
	logic [15:0] pm_addr_o, pm_data_i;
	logic [5:0] io_addr_o;
	logic [7:0] io_wdata_o, io_rdata_i;
	abe_pkg::abe_flags_t status_o, fl;
	logic [7:0] rf [32];
	logic [7:0] iom [64];
	abe_note_t q[$];
	int n_fail = 0;
	int tests_run = 0;
	int seed = 74;
	int pc, acc;
	bit first;

	abe_core i_abe_core (.clock_i(clock_i), .nrst_i(nrst_i), .pm_addr_o(pm_addr_o),
		.pm_data_i(pm_data_i), .io_addr_o(io_addr_o), .io_re_o(io_re_o), .io_we_o(io_we_o),
		.io_wdata_o(io_wdata_o), .io_rdata_i(io_rdata_i), .irq_en_i(irq_en_i),
		.t_flag_i(t_flag_i), .status_o(status_o));
	abe_far_side i_abe_far_side (.clock_i(clock_i), .pm_addr_i(pm_addr_o),
		.pm_data_o(pm_data_i), .io_addr_i(io_addr_o), .io_re_i(io_re_o), .io_we_i(io_we_o),
		.io_wdata_i(io_wdata_o), .io_rdata_o(io_rdata_i));

	function automatic int rnd(input int n);
		return $unsigned($random(seed)) % n;
	endfunction

	task automatic check(input abe_note_t o, input abe_note_t e);
		tests_run++;
		if (o !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, o, e);
		end
	endtask

	task automatic put(input logic [15:0] w, input int c);
		i_abe_far_side.rom[pc] = w;
		pc++;
		acc += c;
	endtask

	// Reference ALU: 0 add, 1 sub, 2 and, 3 or, 4 xor, 5 inc, 6 dec
	task automatic alu(input int k, input logic [4:0] d, input logic [7:0] b, input logic ci,
		input bit st);
		logic [7:0] a;
		logic [8:0] r;
		a = rf[d];
		case (k)
			2: r = {1'b0, a & b};
			3: r = {1'b0, a | b};
			4: r = {1'b0, a ^ b};
			5: r = a + 9'h001;
			6: r = a - 9'h001;
			default: r = k ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
		endcase
		if (k < 2) begin
			fl.c = r[8];
			fl.h = k ? {1'b0, a[3:0]} < b[3:0] + ci : {1'b0, a[3:0]} + b[3:0] + ci > 5'h0f;
		end
		if (k < 2) fl.v = (a[7] ^ b[7]) == k[0] && r[7] != a[7];
		else fl.v = k == 5 ? a == 8'h7f : k == 6 && a == 8'h80;
		fl.n = r[7];
		fl.z = r[7:0] == 8'h00;
		fl.s = fl.n ^ fl.v;
		if (st) rf[d] = r[7:0];
	endtask

	task automatic clr(input logic [4:0] d);
		rf[d] = 8'h00;
		alu(3, d, 8'h00, 1'b0, 1'b1);
		put({4'h8, 4'h3, 3'h0, d}, 1);
	endtask

	task automatic imm(input logic [3:0] op, input logic [4:0] d, input logic [7:0] k);
		case (op)
			4'h3, 4'h4: alu(1, d, k, op[0] ? 1'b0 : fl.c, 1'b1);
			4'h5: alu(2, d, k, 1'b0, 1'b1);
			4'h6: alu(3, d, k, 1'b0, 1'b1);
			default: alu(1, d, k, 1'b0, 1'b0);
		endcase
		put({op, d[3:0], k}, 1);
	endtask

	task automatic word(input bit sb, input logic [1:0] p, input logic [5:0] k);
		logic [15:0] w, r;
		logic [4:0] lo;
		lo = 5'h18 + {p, 1'b0};
		w = {rf[lo + 5'h01], rf[lo]};
		r = sb ? w - k : w + k;
		fl.c = sb ? w < k : r < w;
		fl.v = sb ? w[15] & ~r[15] : ~w[15] & r[15];
		fl.n = r[15];
		fl.z = r == 16'h0000;
		fl.s = fl.n ^ fl.v;
		{rf[lo + 5'h01], rf[lo]} = r;
		put({sb ? 4'ha : 4'h9, 4'h0, p, k}, 2);
	endtask

	// Bit set or clear; a write is expected only inside the allowed range
	task automatic iob(input logic [1:0] g, input logic [5:0] a, input logic [2:0] b);
		logic [7:0] d;
		d = iom[a];
		d[b] = g[0];
		if (a > 6'h02 && a < 6'h20) begin
			q.push_back({a, d, fl, acc[7:0]});
			acc = 0;
			iom[a] = (iom[a] & ~d & 8'hc0) | (d & 8'h3f);
		end
		put({4'hb, g, 1'b0, a, b}, 2);
	endtask

	// Word that must be passed over unless run is set
	task automatic poison(input bit run);
		if (run) iob(2'h1, 6'h11, 3'h0);
		else put({4'hb, 2'h1, 1'b0, 6'h11, 3'h0}, 0);
	endtask

	task automatic block();
		int k, f, two, sk;
		logic [4:0] d, r;
		logic [2:0] b;
		logic [5:0] a;
		logic [15:0] t;
		k = rnd(7);
		f = rnd(9);
		two = rnd(2);
		d = 5'(16 + rnd(16));
		r = rnd(2) ? d : 5'(16 + rnd(16));
		b = 3'(rnd(8));
		a = 6'(rnd(32));
		case (k)
			0: begin
				alu(f < 4 ? f / 2 : f < 7 ? f - 2 : 1, d, rf[r],
					(f == 1 || f == 3 || f == 8) & fl.c, f < 7);
				put({2'b00, 4'(f), d, r}, 1);
			end
			1: imm(4'(3 + rnd(5)), d, 8'(rnd(256)));
			2: begin
				f = f % 4;
				if (f == 3) rf[d] = 8'h00;
				alu(f == 0 ? 5 : f == 1 ? 6 : f == 2 ? 2 : 3, d, f == 2 ? rf[d] : 8'h00,
					1'b0, f != 2);
				put({4'h8, 2'h0, 2'(f), 3'h0, d}, 1);
			end
			3: word(1'(two), 2'(rnd(4)), 6'(rnd(64)));
			4: begin
				sk = fl[b] == two;
				put({4'hc, 1'(two), b, 1'b0, 7'h01}, sk ? 2 : 1);
				poison(!sk);
			end
			5: begin
				f = f % 5;
				case (f)
					0: sk = rf[d] == rf[r];
					1, 2: sk = rf[r][b] == f[1];
					default: sk = iom[a][b] == (f == 4);
				endcase
				t = f == 0 ? {6'h09, d, r} : f < 3 ? {4'h8, 2'(f), 2'h0, b, r}
					: {4'hb, 2'(f - 1), 1'b0, a, b};
				put(t, sk ? 2 + two : 1);
				if (two) begin
					put(16'hd000, sk ? 0 : 2);
					poison(1'b0);
				end
				else poison(!sk);
			end
			default: begin
				t = 16'(pc + 6);
				clr(5'h1e);
				imm(4'h6, 5'h1e, t[7:0]);
				clr(5'h1f);
				imm(4'h6, 5'h1f, t[15:8]);
				put(16'h8c00, 2);
				poison(1'b0);
			end
		endcase
		iob(2'(rnd(2)), 6'(rnd(40)), b);
	endtask

	task print_verdict;
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	// Scoreboard: each write is matched to the oldest note
	initial begin : watch
		abe_note_t e;
		int cnt;
		cnt = 0;
		forever begin
			@(negedge clock_i);
			cnt++;
			if (io_we_o === 1'b1) begin
				e = q.size() ? q.pop_front() : '1;
				if (first) e.dt = cnt[7:0];
				first = 1'b0;
				check({io_addr_o, io_wdata_o, status_o, cnt[7:0]}, e);
				cnt = 0;
			end
		end
	end

	// Whole run takes several hundred cycles
	initial begin : watchdog
		#100000;
		n_fail++;
		print_verdict();
	end

	initial begin : main
		nrst_i = 1'b0;
		irq_en_i = 1'b0;
		t_flag_i = 1'b0;
		for (int run = 0; run < 4; run++) begin
			@(negedge clock_i);
			nrst_i = 1'b0;
			{irq_en_i, t_flag_i} = 2'(run);
			fl = {2'(run), 6'h00};
			pc = 0;
			acc = 0;
			first = 1'b1;
			for (int i = 0; i < 256; i++) i_abe_far_side.rom[i] = 16'he000;
			for (int i = 0; i < 64; i++) begin
				iom[i] = 8'(rnd(256));
				i_abe_far_side.io[i] = iom[i];
			end
			for (int i = 16; i < 32; i++) begin
				clr(5'(i));
				imm(4'h6, 5'(i), 8'(rnd(256)));
			end
			repeat (24) block();
			repeat (3) @(negedge clock_i);
			check({6'h00, pm_addr_o, status_o}, '0);
			nrst_i = 1'b1;
			for (int i = 0; i < 2000 && q.size() > 0; i++) @(negedge clock_i);
			repeat (10) @(negedge clock_i);
			check(30'(q.size()), '0);
		end
		print_verdict();
	end
endmodule // alu_branch_execute_tb_top
`default_nettype wire
